// [core/tvd_pkg.sv]
/*
 package for the trap vector, delegation and extension status block.
 assumes one hart, 32-bit native width, access over an axi4-lite slave.
*/
// Summary of operation
// - extension status fields are two bits: off, initial, clean, dirty.
// - any access to an extension while off raises illegal instruction; status stays off.
// - an enable-unit instruction always executes and leaves status at initial.
// - the dirty summary bit is set when any status field holds dirty.
// - machine and supervisor levels share one copy of the status fields.
// - the trap vector register always exists and is writable with legal values.
// - the vector base is always aligned to four bytes.
// - direct mode sends every machine-level trap to the base.
// - vectored mode sends machine-level interrupts to base plus four times the cause.
// - traps go to machine level unless delegation applies.
// - the exception delegation register is 64 bits and read/write.
// - a set delegation bit routes supervisor or user traps to supervisor.
// - delegated trap writes supervisor cause, pc, value, prior privilege, prior enable; clears enable.
// - a delegated trap leaves machine cause, pc, value and prior fields alone.
// - unimplemented delegation bits read back zero after writing all ones.
// - no exception delegation bit reads as a fixed one.
// - machine-level interrupt delegation bits are never fixed at one.
// - traps never go to a less privileged level than the current one.
// - a delegated trap taken while at supervisor stays at supervisor.
// - delegated interrupts are masked while running at machine level.
// - each exception delegation bit index equals its exception cause.
// - at 32-bit width a high register aliases delegation bits 63 to 32.
// - interrupt delegation bits follow pending-interrupt positions; supervisor timer is bit 5.
// - exception delegation bit 11 is always zero.
package tvd_pkg;
	localparam int XW = 32;
	localparam logic [1:0] ST_OFF = 2'h0;
	localparam logic [1:0] ST_INIT = 2'h1;
	localparam logic [1:0] ST_CLEAN = 2'h2;
	localparam logic [1:0] ST_DIRTY = 2'h3;
	localparam logic [1:0] MODE_DIRECT = 2'h0;
	localparam logic [1:0] MODE_VECTORED = 2'h1;
	localparam logic [1:0] PRIV_U = 2'h0;
	localparam logic [1:0] PRIV_S = 2'h1;
	localparam logic [1:0] PRIV_M = 2'h3;
	// register byte addresses
	localparam logic [7:0] A_TVEC = 8'h00;
	localparam logic [7:0] A_EDEL = 8'h04;
	localparam logic [7:0] A_EDELH = 8'h08;
	localparam logic [7:0] A_IDEL = 8'h0C;
	localparam logic [7:0] A_XSTAT = 8'h10;
	localparam logic [7:0] A_STRAP = 8'h14;
	localparam logic [7:0] A_SCAUSE = 8'h18;
	localparam logic [7:0] A_SEPC = 8'h1C;
	localparam logic [7:0] A_STVAL = 8'h20;
	// ext status register fields
	localparam int F_FS = 0;
	localparam int F_VS = 2;
	localparam int F_XS = 4;
	localparam int F_SD = 31;
	// supervisor trap state fields
	localparam int F_SIE = 0;
	localparam int F_SUPERVISOR_PRIOR_INT_ENABLE = 1;
	localparam int F_SPP = 2;
	// implemented delegation masks; bit 11 and all machine irqs held zero
	localparam logic [63:0] EDEL_MASK = 64'h0000_0000_0000_B3FF;
	localparam logic [XW-1:0] IDEL_MASK = 32'h0000_0222;
	localparam logic [XW-1:0] TVEC_RST = 32'h0000_0000;
	localparam logic [XW-1:0] BASE_MASK = 32'hFFFF_FFFC;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	// extension instruction classes
	typedef enum logic [2:0] {OP_NONE, OP_READ, OP_MODIFY, OP_UNCONFIG, OP_DISABLE, OP_ENABLE} tvd_op_t;
endpackage

// [core/tvd_core.sv]
/*
 trap vector selection, trap delegation and extension status for one hart.
 assumes the pipeline offers one trap or one extension operation per cycle,
 and a single axi4-lite master.
*/
`timescale 1ns/1ps
module tvd_core
	import tvd_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// trap request from pipeline
	input wire logic trap_valid,
	input wire logic trap_is_irq,
	input wire logic [5:0] trap_cause,
	input wire logic [XW-1:0] trap_pc,
	input wire logic [XW-1:0] trap_val,
	input wire logic [1:0] cur_priv,
	// trap answer
	output logic redirect_valid,
	output logic [XW-1:0] redirect_pc,
	output logic redirect_to_s,
	output logic [XW-1:0] irq_deleg_mask,
	// extension operation from pipeline
	input wire logic ext_op_valid,
	input wire tvd_op_t ext_op,
	input wire logic [1:0] ext_unit,
	output logic ext_illegal
);
	logic [XW-1:0] tvec_reg;
	logic [63:0] edel_reg;
	logic [XW-1:0] idel_reg;
	logic [1:0] fs_reg, vs_reg, xs_reg;
	logic sie_reg, supervisor_prior_int_enable_reg;
	logic [1:0] spp_reg;
	logic [XW-1:0] scause_reg, sepc_reg, stval_reg;
	logic aw_full, w_full;
	logic [7:0] aw_reg;
	logic [31:0] w_reg;
	logic [3:0] ws_reg;
	logic rd_pend;
	logic [7:0] ar_reg;

	// write path: address and data taken in either order
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire do_wr = aw_full && w_full && !s_axi_bvalid;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	// next handshake state, so the readies can come from flops
	wire aw_full_next = !do_wr && (aw_take || aw_full);
	wire w_full_next = !do_wr && (w_take || w_full);
	wire bvalid_next = do_wr || (s_axi_bvalid && !s_axi_bready);
	wire rvalid_next = rd_pend || (s_axi_rvalid && !s_axi_rready);
	wire [31:0] wmask = {{8{ws_reg[3]}}, {8{ws_reg[2]}}, {8{ws_reg[1]}}, {8{ws_reg[0]}}};
	wire wr_tvec = do_wr && aw_reg == A_TVEC;
	wire wr_edel = do_wr && aw_reg == A_EDEL;
	wire wr_edelh = do_wr && aw_reg == A_EDELH;
	wire wr_idel = do_wr && aw_reg == A_IDEL;
	wire wr_xstat = do_wr && aw_reg == A_XSTAT;
	wire wr_strap = do_wr && aw_reg == A_STRAP;
	wire wr_known = wr_tvec | wr_edel | wr_edelh | wr_idel | wr_xstat | wr_strap
		| (do_wr && (aw_reg == A_SCAUSE || aw_reg == A_SEPC || aw_reg == A_STVAL));
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction
	// mode follows the merged lanes, so a write without lane 0 keeps it
	wire [XW-1:0] tvec_wr = merge(tvec_reg, w_reg, wmask);

	wire sd = (fs_reg == ST_DIRTY) || (vs_reg == ST_DIRTY) || (xs_reg == ST_DIRTY);
	wire [31:0] xstat_rd = {sd, 25'h0, xs_reg, vs_reg, fs_reg};
	wire [31:0] strap_rd = {29'h0, spp_reg[0], supervisor_prior_int_enable_reg, sie_reg};
	wire ar_known = ar_reg == A_TVEC || ar_reg == A_EDEL || ar_reg == A_EDELH || ar_reg == A_IDEL
		|| ar_reg == A_XSTAT || ar_reg == A_STRAP || ar_reg == A_SCAUSE || ar_reg == A_SEPC || ar_reg == A_STVAL;
	wire [31:0] rd_mux = ar_reg == A_TVEC ? tvec_reg :
		ar_reg == A_EDEL ? edel_reg[31:0] :
		ar_reg == A_EDELH ? edel_reg[63:32] :
		ar_reg == A_IDEL ? idel_reg :
		ar_reg == A_XSTAT ? xstat_rd :
		ar_reg == A_STRAP ? strap_rd :
		ar_reg == A_SCAUSE ? scause_reg :
		ar_reg == A_SEPC ? sepc_reg :
		ar_reg == A_STVAL ? stval_reg : 32'h0000_0000;

	// never delegate out of machine level
	wire below_m = cur_priv != PRIV_M;
	wire deleg_bit = trap_is_irq ? idel_reg[trap_cause[4:0]] : edel_reg[trap_cause];
	// route delegated lower-level traps to supervisor
	wire to_s = trap_valid && below_m && deleg_bit;
	wire [XW-1:0] base = tvec_reg & BASE_MASK;
	wire [XW-1:0] vec_off = {{(XW-8){1'b0}}, trap_cause, 2'h0};
	// vectored interrupts offset by four times cause
	wire [XW-1:0] m_target = (tvec_reg[1:0] == MODE_VECTORED && trap_is_irq) ? base + vec_off : base;

	// extension status selection
	wire [1:0] cur_st = ext_unit == 2'h0 ? fs_reg : ext_unit == 2'h1 ? vs_reg : xs_reg;
	logic [1:0] st_next;
	logic ill_next;
	always_comb
	begin
		st_next = cur_st;
		ill_next = 1'b0;
		case (ext_op)
			OP_READ: ill_next = cur_st == ST_OFF;
			OP_MODIFY:
			begin
				ill_next = cur_st == ST_OFF;
				st_next = cur_st == ST_OFF ? ST_OFF : ST_DIRTY;
			end
			OP_UNCONFIG:
			begin
				ill_next = cur_st == ST_OFF;
				st_next = cur_st == ST_OFF ? ST_OFF : ST_INIT;
			end
			OP_DISABLE: st_next = ST_OFF;
			OP_ENABLE: st_next = ST_INIT;
			default: st_next = cur_st;
		endcase
	end

	// axi handshakes
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_reg <= 8'h00;
			w_reg <= 32'h0000_0000;
			ws_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OK;
		end
		else
		begin
			if (aw_take)
			begin
				aw_full <= 1'b1;
				aw_reg <= s_axi_awaddr;
			end
			if (w_take)
			begin
				w_full <= 1'b1;
				w_reg <= s_axi_wdata;
				ws_reg <= s_axi_wstrb;
			end
			if (do_wr)
			begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? RESP_OK : RESP_ERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rd_pend <= 1'b0;
			ar_reg <= 8'h00;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OK;
		end
		else if (ar_take)
		begin
			rd_pend <= 1'b1;
			ar_reg <= s_axi_araddr;
		end
		else if (rd_pend)
		begin
			rd_pend <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= ar_known ? RESP_OK : RESP_ERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
	// readies registered; new requests refused while a response is pending
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_arready <= 1'b1;
		end
		else
		begin
			s_axi_awready <= !aw_full_next && !bvalid_next;
			s_axi_wready <= !w_full_next && !bvalid_next;
			s_axi_arready <= !ar_take && !rvalid_next;
		end
	end

	// delegation and vector registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tvec_reg <= TVEC_RST;
			edel_reg <= 64'h0;
			idel_reg <= 32'h0000_0000;
		end
		else
		begin
			// writable base, aligned, reserved modes fall back to direct
			if (wr_tvec)
				tvec_reg <= (tvec_wr & BASE_MASK)
					| {30'h0, (tvec_wr[1:0] == MODE_VECTORED) ? MODE_VECTORED : MODE_DIRECT};
			if (wr_edel)
				edel_reg[31:0] <= merge(edel_reg[31:0], w_reg, wmask) & EDEL_MASK[31:0];
			if (wr_edelh)
				edel_reg[63:32] <= merge(edel_reg[63:32], w_reg, wmask) & EDEL_MASK[63:32];
			// only supervisor irq positions, supervisor timer at 5
			if (wr_idel)
				idel_reg <= merge(idel_reg, w_reg, wmask) & IDEL_MASK;
		end
	end

	// single shared status copy; software writes update fs and vs only, instructions update all three
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			fs_reg <= ST_OFF;
			vs_reg <= ST_OFF;
			xs_reg <= ST_OFF;
			ext_illegal <= 1'b0;
		end
		else
		begin
			ext_illegal <= ext_op_valid && ill_next;
			// two-bit fields; instruction update wins over a same-cycle write
			if (ext_op_valid && ext_unit == 2'h0)
				fs_reg <= st_next;
			else if (wr_xstat && ws_reg[0])
				fs_reg <= w_reg[F_FS +: 2];
			if (ext_op_valid && ext_unit == 2'h1)
				vs_reg <= st_next;
			else if (wr_xstat && ws_reg[0])
				vs_reg <= w_reg[F_VS +: 2];
			if (ext_op_valid && ext_unit == 2'h2)
				xs_reg <= st_next;
		end
	end

	// supervisor trap state and redirect
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sie_reg <= 1'b0;
			supervisor_prior_int_enable_reg <= 1'b0;
			spp_reg <= PRIV_U;
			scause_reg <= 32'h0000_0000;
			sepc_reg <= 32'h0000_0000;
			stval_reg <= 32'h0000_0000;
			redirect_valid <= 1'b0;
			redirect_pc <= 32'h0000_0000;
			redirect_to_s <= 1'b0;
			irq_deleg_mask <= 32'h0000_0000;
		end
		else
		begin
			redirect_valid <= trap_valid;
			redirect_to_s <= to_s;
			// delegated irqs masked while in machine level
			irq_deleg_mask <= idel_reg;
			if (to_s)
			begin
				scause_reg <= {trap_is_irq, {(XW-7){1'b0}}, trap_cause};
				sepc_reg <= trap_pc;
				stval_reg <= trap_val;
				spp_reg <= cur_priv;
				supervisor_prior_int_enable_reg <= sie_reg;
				sie_reg <= 1'b0;
				// redirect_to_s keeps machine trap state untouched
				redirect_pc <= base;
			end
			else
			begin
				if (wr_strap && ws_reg[0])
				begin
					sie_reg <= w_reg[F_SIE];
					supervisor_prior_int_enable_reg <= w_reg[F_SUPERVISOR_PRIOR_INT_ENABLE];
					spp_reg <= {1'b0, w_reg[F_SPP]};
				end
				if (trap_valid)
					redirect_pc <= m_target;
			end
		end
	end

	// assertions
	sequence s_modify_live;
		ext_op_valid && ext_op == OP_MODIFY && ext_unit != 2'h3 && cur_st != ST_OFF;
	endsequence
	property p_sd;
		@(posedge clk) disable iff (rst) s_modify_live |=> xstat_rd[F_SD];
	endproperty
	a_sd: assert property (p_sd) else $error("summary bit not set on dirty");
	property p_off_ill;
		@(posedge clk) disable iff (rst) (ext_op_valid && ext_op == OP_READ && ext_unit == 2'h0 && fs_reg == ST_OFF)
			|=> (ext_illegal && fs_reg == ST_OFF);
	endproperty
	a_off_ill: assert property (p_off_ill) else $error("off read did not trap");
	property p_mod;
		@(posedge clk) disable iff (rst) (ext_op_valid && ext_op == OP_MODIFY && ext_unit == 2'h1 && vs_reg != ST_OFF)
			|=> vs_reg == ST_DIRTY && !ext_illegal;
	endproperty
	a_mod: assert property (p_mod) else $error("modify did not go dirty");
	property p_en;
		@(posedge clk) disable iff (rst) (ext_op_valid && ext_op == OP_ENABLE && ext_unit == 2'h0) |=> fs_reg == ST_INIT;
	endproperty
	a_en: assert property (p_en) else $error("enable not initial");
	property p_align;
		@(posedge clk) disable iff (rst) redirect_valid && !redirect_to_s && !$past(trap_is_irq) |-> redirect_pc[1:0] == 2'h0;
	endproperty
	a_align: assert property (p_align) else $error("vector not aligned");
	property p_m_stay;
		@(posedge clk) disable iff (rst) (trap_valid && cur_priv == PRIV_M) |=> !redirect_to_s;
	endproperty
	a_m_stay: assert property (p_m_stay) else $error("machine trap delegated");
	property p_sdel;
		@(posedge clk) disable iff (rst) to_s |=> (sepc_reg == $past(trap_pc) && !sie_reg && supervisor_prior_int_enable_reg == $past(sie_reg));
	endproperty
	a_sdel: assert property (p_sdel) else $error("supervisor trap state wrong");
	property p_b11;
		@(posedge clk) disable iff (rst) !edel_reg[11] && !idel_reg[11] && !idel_reg[7];
	endproperty
	a_b11: assert property (p_b11) else $error("fixed zero bit set");
	property p_vec;
		@(posedge clk) disable iff (rst) (trap_valid && !to_s && trap_is_irq && tvec_reg[1:0] == MODE_VECTORED)
			|=> redirect_pc == $past(base) + {24'h0, $past(trap_cause), 2'h0};
	endproperty
	a_vec: assert property (p_vec) else $error("vectored target wrong");
	property p_direct;
		@(posedge clk) disable iff (rst) (trap_valid && !to_s && tvec_reg[1:0] == MODE_DIRECT)
			|=> redirect_pc == $past(base);
	endproperty
	a_direct: assert property (p_direct) else $error("direct target not base");
	sequence s_deleg_trap;
		trap_valid && below_m && deleg_bit;
	endsequence
	property p_s_keep;
		@(posedge clk) disable iff (rst) s_deleg_trap |=> redirect_valid && redirect_to_s;
	endproperty
	a_s_keep: assert property (p_s_keep) else $error("delegated trap not sent to supervisor");
	property p_scause;
		@(posedge clk) disable iff (rst) s_deleg_trap |=> spp_reg == $past(cur_priv)
			&& scause_reg[5:0] == $past(trap_cause) && scause_reg[XW-1] == $past(trap_is_irq);
	endproperty
	a_scause: assert property (p_scause) else $error("supervisor cause or prior level wrong");
endmodule

// [bench/tvd_pipe_model.sv]
/*
 pipeline stand-in: fires traps and extension operations at the block.
 assumes the bench calls its tasks from one process.
*/
`timescale 1ns/1ps
module tvd_pipe_model
	import tvd_pkg::*;
(
	// clock
	input wire logic clk,
	// trap side
	output logic trap_valid,
	output logic trap_is_irq,
	output logic [5:0] trap_cause,
	output logic [XW-1:0] trap_pc,
	output logic [XW-1:0] trap_val,
	output logic [1:0] cur_priv,
	input wire logic [XW-1:0] irq_deleg_mask,
	// extension side
	output logic ext_op_valid,
	output tvd_op_t ext_op,
	output logic [1:0] ext_unit
);
	initial
	begin
		trap_valid = 1'b0;
		trap_is_irq = 1'b0;
		trap_cause = 6'h0;
		trap_pc = 32'h0;
		trap_val = 32'h0;
		cur_priv = PRIV_M;
		ext_op_valid = 1'b0;
		ext_op = OP_NONE;
		ext_unit = 2'h0;
	end
	task automatic fire_trap(input logic irq, input logic [5:0] c, input logic [31:0] pc, input logic [1:0] p,
		output logic fired);
		fired = !(irq && p == PRIV_M && irq_deleg_mask[c[4:0]]);
		if (fired)
		begin
			@(posedge clk);
			trap_valid <= 1'b1;
			trap_is_irq <= irq;
			trap_cause <= c;
			trap_pc <= pc;
			trap_val <= ~pc;
			cur_priv <= p;
			@(posedge clk);
			trap_valid <= 1'b0;
			// released pc and value lines flip; irq, cause and level hold
			trap_pc <= ~pc;
			trap_val <= pc;
		end
	endtask
	task automatic fire_ext(input tvd_op_t op, input logic [1:0] u);
		@(posedge clk);
		ext_op_valid <= 1'b1;
		ext_op <= op;
		ext_unit <= u;
		@(posedge clk);
		ext_op_valid <= 1'b0;
		ext_op <= OP_NONE;
	endtask
endmodule

// [bench/tb_top.sv]
/*
 bench for tvd_core: axi4-lite master, random traps and extension ops.
 assumes the pipeline stand-in tvd_pipe_model.
*/
`timescale 1ns/1ps
module tb_top
	import tvd_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, rdv, r2s, ext_illegal, tv, tirq, eov;
	logic [1:0] bresp, rresp, cpriv, eunit;
	logic [31:0] rdata, rdpc, idmask, tpc, tval;
	logic [5:0] tcause;
	tvd_op_t eop;
	int n_errors = 0;
	int n_tests = 0;
	integer seed = 32'h9CD7E245;
	logic [63:0] edel = 64'h0;
	logic [31:0] idel = 32'h0;
	logic [31:0] tvec = 32'h0;
	logic [1:0] st [3] = '{ST_OFF, ST_OFF, ST_OFF};
	always #10 clk = ~clk;
	tvd_core DUT (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .trap_valid(tv), .trap_is_irq(tirq), .trap_cause(tcause),
		.trap_pc(tpc), .trap_val(tval), .cur_priv(cpriv), .redirect_valid(rdv), .redirect_pc(rdpc),
		.redirect_to_s(r2s), .irq_deleg_mask(idmask), .ext_op_valid(eov), .ext_op(eop), .ext_unit(eunit),
		.ext_illegal(ext_illegal));
	tvd_pipe_model pipe (.clk(clk), .trap_valid(tv), .trap_is_irq(tirq), .trap_cause(tcause), .trap_pc(tpc),
		.trap_val(tval), .cur_priv(cpriv), .irq_deleg_mask(idmask), .ext_op_valid(eov), .ext_op(eop),
		.ext_unit(eunit));
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic tmo();
		n_errors++;
		$display("Error handshake expected answer seen timeout");
		test_done();
	endtask
	// handshake seen at negedge is the one taken at the next rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic at, wt, bt;
		logic [1:0] r;
		int i;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 99; i++)
		begin
			@(negedge clk);
			at = awvalid && awready;
			wt = wvalid && wready;
			bt = bvalid;
			r = bresp;
			@(posedge clk);
			if (at)
				awvalid <= 1'b0;
			if (wt)
				wvalid <= 1'b0;
			if (bt)
				break;
		end
		bready <= 1'b0;
		if (i == 99)
			tmo();
		chk("bresp", 32'(e), 32'(r));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic at, rt;
		logic [31:0] d;
		logic [1:0] r;
		int i;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 99; i++)
		begin
			@(negedge clk);
			at = arvalid && arready;
			rt = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (at)
				arvalid <= 1'b0;
			if (rt)
				break;
		end
		rready <= 1'b0;
		if (i == 99)
			tmo();
		chk("rresp", 32'(er), 32'(r));
		if (er == RESP_OK)
			chk($sformatf("reg %h", a), e, d);
	endtask
	function automatic logic [1:0] st_next(input tvd_op_t op, input logic [1:0] s);
		case (op)
			OP_MODIFY: st_next = (s == ST_OFF) ? ST_OFF : ST_DIRTY;
			OP_UNCONFIG: st_next = (s == ST_OFF) ? ST_OFF : ST_INIT;
			OP_DISABLE: st_next = ST_OFF;
			OP_ENABLE: st_next = ST_INIT;
			default: st_next = s;
		endcase
	endfunction
	function automatic logic ill(input tvd_op_t op, input logic [1:0] s);
		ill = s == ST_OFF && (op == OP_READ || op == OP_MODIFY || op == OP_UNCONFIG);
	endfunction
	function automatic logic [31:0] xs_exp();
		xs_exp = {st[0] == ST_DIRTY || st[1] == ST_DIRTY || st[2] == ST_DIRTY, 25'h0, st[2], st[1], st[0]};
	endfunction
	function automatic logic [32:0] trap_exp(input logic irq, input logic [5:0] c, input logic [1:0] p);
		logic dl;
		dl = p != PRIV_M && (irq ? idel[c[4:0]] : edel[c]);
		trap_exp = {dl, (tvec & BASE_MASK) + ((!dl && irq && tvec[1:0] == MODE_VECTORED) ? 32'(c) << 2 : 32'h0)};
	endfunction
	initial
	begin
		logic [7:0] regs [6] = '{A_TVEC, A_EDEL, A_EDELH, A_IDEL, A_XSTAT, A_STRAP};
		logic [31:0] d, pc;
		logic [32:0] x;
		logic [5:0] c;
		logic [1:0] p, u;
		logic irq, fired, supervisor_irq_enable;
		tvd_op_t op;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		foreach (regs[k])
			rd(regs[k], 32'h0, RESP_OK);
		wr(A_EDEL, 32'hFFFF_FFFF, RESP_OK);
		rd(A_EDEL, EDEL_MASK[31:0], RESP_OK);
		wr(A_EDELH, 32'hFFFF_FFFF, RESP_OK);
		rd(A_EDELH, EDEL_MASK[63:32], RESP_OK);
		wr(A_IDEL, 32'hFFFF_FFFF, RESP_OK);
		rd(A_IDEL, IDEL_MASK, RESP_OK);
		chk("irq mask", IDEL_MASK, idmask);
		rd(8'h40, 32'h0, RESP_ERR);
		wr(8'h44, 32'h1, RESP_ERR);
		$display("test registers done");
		for (int t = 0; t < 48; t++)
		begin
			if (t % 8 == 0)
			begin
				d = $random(seed);
				d[1] = 1'b0;
				wr(A_TVEC, d, RESP_OK);
				tvec = d;
				rd(A_TVEC, tvec, RESP_OK);
				edel = {32'h0, $random(seed)} & EDEL_MASK;
				wr(A_EDEL, edel[31:0], RESP_OK);
				idel = $random(seed) & IDEL_MASK;
				wr(A_IDEL, idel, RESP_OK);
				rd(A_EDEL, edel[31:0], RESP_OK);
			end
			irq = 1'($random(seed));
			c = 6'($unsigned($random(seed)) % 16);
			p = t % 3 == 2 ? PRIV_M : 2'(t % 3);
			pc = $random(seed);
			supervisor_irq_enable = 1'($random(seed));
			wr(A_STRAP, {31'h0, supervisor_irq_enable}, RESP_OK);
			x = trap_exp(irq, c, p);
			pipe.fire_trap(irq, c, pc, p, fired);
			if (fired)
			begin
				@(negedge clk);
				chk("redirect valid", 32'h1, 32'(rdv));
				chk("redirect pc", x[31:0], rdpc);
				chk("to supervisor", 32'(x[32]), 32'(r2s));
				@(negedge clk);
				chk("redirect pulse", 32'h0, 32'(rdv));
				rd(A_STRAP, x[32] ? {29'h0, p == PRIV_S, supervisor_irq_enable, 1'b0} : {31'h0, supervisor_irq_enable}, RESP_OK);
				if (x[32])
				begin
					rd(A_SEPC, pc, RESP_OK);
					rd(A_STVAL, ~pc, RESP_OK);
					rd(A_SCAUSE, {irq, 25'h0, c}, RESP_OK);
				end
			end
		end
		$display("test traps done");
		for (int t = 0; t < 60; t++)
		begin
			op = tvd_op_t'(3'($unsigned($random(seed)) % 5 + 1));
			u = 2'($unsigned($random(seed)) % 3);
			pipe.fire_ext(op, u);
			@(negedge clk);
			chk("illegal", 32'(ill(op, st[u])), 32'(ext_illegal));
			st[u] = st_next(op, st[u]);
			if (t % 10 == 9)
			begin
				d = $random(seed);
				// save pass cleans dirty fs and vs units only; other passes restore at random
				if (t % 20 == 9)
					d[3:0] = {st[1] == ST_DIRTY ? ST_CLEAN : st[1], st[0] == ST_DIRTY ? ST_CLEAN : st[0]};
				wr(A_XSTAT, d, RESP_OK);
				st[0] = d[1:0];
				st[1] = d[3:2];
			end
			rd(A_XSTAT, xs_exp(), RESP_OK);
		end
		$display("test extension done");
		test_done();
	end
endmodule
